//--- design/srf_map.svh
// Field positions, codes and reset values for the receive formatter.
// Assumes quadlets are 32 bits with bit 31 the most significant.
`ifndef SRF_MAP_SVH
`define SRF_MAP_SVH
`define SRF_TCODE_ISO 4'hA
`define SRF_TAG_FORMATTED 2'h0
`define SRF_ACK_COMPLETE 4'h1
`define SRF_ACK_BUSY_A 4'h5
`define SRF_ACK_BUSY_B 4'h6
`define SRF_ACK_DATA_ERR 4'hD
`define SRF_ACK_CRC_ERR 4'hE
`define SRF_SPD_100 2'h0
`define SRF_SPD_200 2'h1
`define SRF_SPD_400 2'h2
`define SRF_PHYCFG_MARK 16'h00E0
`define SRF_PHYCFG_NIB_LO 4
`define SRF_PHYCFG_NIB_HI 7
`define SRF_PHYCFG_NIB_NEW 4'h0
`define SRF_ATF_ADDR_FIRST 8'h80
`define SRF_ATF_ADDR_SECOND 8'h8C
`define SRF_CYDONE_BIT 0
`define SRF_HDR_LEN_HI 31
`define SRF_HDR_LEN_LO 16
`define SRF_HDR_TAG_HI 15
`define SRF_HDR_TAG_LO 14
`define SRF_HDR_CHAN_HI 13
`define SRF_HDR_CHAN_LO 8
`define SRF_HDR_TCODE_HI 7
`define SRF_HDR_TCODE_LO 4
`define SRF_HDR_SY_HI 3
`define SRF_HDR_SY_LO 0
`define SRF_TRL_SPD_LO 16
`define SRF_TRL_CODE_LO 0
`define SRF_TRL_ACK_LO 4
`define SRF_SID_OK_BIT 0
`define SRF_WORD_ZERO 32'h0000_0000
`endif

//--- design/srf_pkg.sv
// Types shared by the receive formatter modules.
// Assumes the map header supplies all numeric constants.
package srf_pkg;
  typedef enum logic [2:0] {
    SRF_IDLE = 3'b000,
    SRF_ISO = 3'b001,
    SRF_SNOOP = 3'b010,
    SRF_SELFID = 3'b011,
    SRF_TRAIL = 3'b100
  } srf_state_t;
  typedef enum logic [1:0] {
    SRF_KIND_ISO = 2'b00,
    SRF_KIND_SNOOP = 2'b01,
    SRF_KIND_SELFID = 2'b10,
    SRF_KIND_ASYNC = 2'b11
  } srf_kind_t;
endpackage : srf_pkg

//--- design/srf_phycfg_if.sv
// Interface between the receive formatter top and its phy config rewriter.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface srf_phycfg_if;
  logic wr_valid;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic out_valid;
  logic [31:0] out_data;
  logic out_is_cfg;
  modport rewriter (input wr_valid, input wr_addr, input wr_data, output out_valid, output out_data,
    output out_is_cfg);
  modport user (output wr_valid, output wr_addr, output wr_data, input out_valid, input out_data,
    input out_is_cfg);
endinterface : srf_phycfg_if

//--- design/srf_phycfg.sv
// Rewrites phy configuration quadlets passing from the transmit FIFO to the phy.
// Assumes one quadlet per cycle at most on the write side.
`timescale 1ns/1ps
`include "srf_map.svh"
module srf_phycfg (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Quadlet stream
  srf_phycfg_if.rewriter cfg
);
  logic out_valid_q, out_valid_d;
  logic [31:0] out_data_q, out_data_d;
  logic is_cfg_q, is_cfg_d;
  // ==========================================
  // Marker detection and nibble replacement
  always_comb begin
    out_valid_d = cfg.wr_valid;
    out_data_d = cfg.wr_data;
    is_cfg_d = is_cfg_q;
    if (cfg.wr_valid && cfg.wr_addr == `SRF_ATF_ADDR_FIRST) begin
      is_cfg_d = (cfg.wr_data[15:0] == `SRF_PHYCFG_MARK);
      if (cfg.wr_data[15:0] == `SRF_PHYCFG_MARK) begin
        out_data_d[`SRF_PHYCFG_NIB_HI:`SRF_PHYCFG_NIB_LO] = `SRF_PHYCFG_NIB_NEW;
      end
    end else if (cfg.wr_valid && cfg.wr_addr == `SRF_ATF_ADDR_SECOND) begin
      is_cfg_d = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_valid_q <= 1'b0;
      out_data_q <= `SRF_WORD_ZERO;
      is_cfg_q <= 1'b0;
    end else begin
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
      is_cfg_q <= is_cfg_d;
    end
  end
  assign cfg.out_valid = out_valid_q;
  assign cfg.out_data = out_data_q;
  assign cfg.out_is_cfg = is_cfg_q;
endmodule : srf_phycfg

//--- design/srf_rx_format.sv
// Receive-side packet formatter: iso, snoop, cycle mark and self-ID entries into
// the general receive FIFO; phy config rewrite on the transmit path.
// Assumes the receive front end delivers headers and payload quadlets one per cycle.
//
// How it works
// - Header data length bounds payload bytes written
// - Iso entry tag field, 00 formatted
// - Iso entry transaction code is Ah
// - Byte zero first, zero pad last quadlet
// - Iso trailer carries complete, data or CRC error
// - Iso entry keeps channel and sync bits
// - Speed codes 00, 01, 10; 11 undefined
// - Snoop mode accepts every bus packet; a packet starting in the same cycle as cycle_end is dropped, the marker wins
// - Snoop writes whole or partial packet
// - Snoop status complete, else busyA or busyB
// - Snoop trailer holds observed ack, speed
// - Cycle end inserts marker with done flag; a cycle_end outside idle (during a packet or its trailer) inserts none
// - Detect 00E0h, rewrite Eh nibble to 0h
// - Config with both flags clear ignored; rewriter does not check flags, edits any 00E0h written at address 80h
// - Self-ID enable stores self-ID in FIFO
// - Self-ID status flag marks correct data
`timescale 1ns/1ps
`include "srf_map.svh"
module srf_rx_format #(
  parameter int LEN_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic snoop_enable,
  input wire logic receive_selfid_enable,
  // Receive front end
  input wire logic rx_start,
  input wire srf_pkg::srf_kind_t rx_kind,
  input wire logic [31:0] rx_header,
  input wire logic rx_addr_match,
  input wire logic rx_valid,
  input wire logic [31:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_truncated,
  input wire logic rx_crc_ok,
  input wire logic rx_data_ok,
  input wire logic [1:0] rx_speed,
  input wire logic [3:0] rx_ack_seen,
  input wire logic cycle_end,
  // General receive FIFO write side
  output logic general_receive_fifo_wr,
  output logic [31:0] general_receive_fifo_data,
  // Transmit FIFO to phy path
  input wire logic async_transmit_fifo_wr,
  input wire logic [7:0] async_transmit_fifo_addr,
  input wire logic [31:0] async_transmit_fifo_data,
  output logic phy_tx_valid,
  output logic [31:0] phy_tx_data,
  output logic phy_tx_is_cfg
);
  srf_pkg::srf_state_t state_q, state_d;
  logic [LEN_W-1:0] remain_q, remain_d;
  logic busy_b_q, busy_b_d;
  logic wr_q, wr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] code_q, code_d;
  logic [31:0] mask;
  logic [31:0] iso_hdr;
  srf_phycfg_if cfg_if ();

  // ==========================================
  // Byte mask for the final payload quadlet
  always_comb begin
    mask = 32'hFFFF_FFFF;
    if (remain_q < LEN_W'(4)) begin
      for (int b = 0; b < 4; b++) begin
        if (LEN_W'(b) >= remain_q) begin
          mask[31-8*b -: 8] = 8'h00;
        end
      end
    end
  end

  always_comb begin
    iso_hdr = rx_header;
    iso_hdr[`SRF_HDR_TAG_HI:`SRF_HDR_TAG_LO] = `SRF_TAG_FORMATTED;
    iso_hdr[`SRF_HDR_TCODE_HI:`SRF_HDR_TCODE_LO] = `SRF_TCODE_ISO;
  end

  // ==========================================
  // Trailer status codes, taken when the packet ends
  logic iso_short;
  logic [3:0] iso_code;
  logic [3:0] snoop_code;
  logic [3:0] sid_code;
  always_comb begin
    iso_short = (remain_q > LEN_W'(4)) || (remain_q != '0 && !rx_valid);
    if (!rx_crc_ok) begin
      iso_code = `SRF_ACK_CRC_ERR;
    end else if (!rx_data_ok || iso_short) begin
      iso_code = `SRF_ACK_DATA_ERR;
    end else begin
      iso_code = `SRF_ACK_COMPLETE;
    end
    if (!rx_truncated) begin
      snoop_code = `SRF_ACK_COMPLETE;
    end else if (busy_b_q) begin
      snoop_code = `SRF_ACK_BUSY_B;
    end else begin
      snoop_code = `SRF_ACK_BUSY_A;
    end
    sid_code = {3'h0, rx_crc_ok & rx_data_ok};
  end

  // ==========================================
  // Entry sequencer
  always_comb begin
    state_d = state_q;
    remain_d = remain_q;
    busy_b_d = busy_b_q;
    wr_d = 1'b0;
    wdata_d = wdata_q;
    code_d = code_q;
    case (state_q)
      srf_pkg::SRF_IDLE: begin
        if (cycle_end) begin
          wr_d = 1'b1;
          wdata_d = `SRF_WORD_ZERO;
          wdata_d[`SRF_CYDONE_BIT] = 1'b1;
        end else if (rx_start && snoop_enable) begin
          state_d = srf_pkg::SRF_SNOOP;
          wr_d = 1'b1;
          wdata_d = rx_header;
        end else if (rx_start && rx_kind == srf_pkg::SRF_KIND_ISO) begin
          state_d = srf_pkg::SRF_ISO;
          remain_d = LEN_W'(rx_header[`SRF_HDR_LEN_HI:`SRF_HDR_LEN_LO]);
          wr_d = 1'b1;
          wdata_d = iso_hdr;
        end else if (rx_start && rx_kind == srf_pkg::SRF_KIND_SELFID && receive_selfid_enable) begin
          state_d = srf_pkg::SRF_SELFID;
          wr_d = 1'b1;
          wdata_d = rx_header;
        end
      end
      srf_pkg::SRF_ISO: begin
        if (rx_valid && remain_q != '0) begin
          wr_d = 1'b1;
          wdata_d = rx_data & mask;
          remain_d = (remain_q > LEN_W'(4)) ? remain_q - LEN_W'(4) : '0;
        end
        if (rx_end) begin
          state_d = srf_pkg::SRF_TRAIL;
          code_d = iso_code;
        end
      end
      srf_pkg::SRF_SNOOP: begin
        if (rx_valid) begin
          wr_d = 1'b1;
          wdata_d = rx_data;
        end
        if (rx_end) begin
          state_d = srf_pkg::SRF_TRAIL;
          code_d = snoop_code;
          busy_b_d = rx_truncated ^ busy_b_q;
        end
      end
      srf_pkg::SRF_SELFID: begin
        if (rx_valid) begin
          wr_d = 1'b1;
          wdata_d = rx_data;
        end
        if (rx_end) begin
          state_d = srf_pkg::SRF_TRAIL;
          code_d = sid_code;
        end
      end
      srf_pkg::SRF_TRAIL: begin
        state_d = srf_pkg::SRF_IDLE;
        wr_d = 1'b1;
        wdata_d = `SRF_WORD_ZERO;
        wdata_d[`SRF_TRL_SPD_LO +: 2] = rx_speed;
        wdata_d[`SRF_TRL_CODE_LO +: 4] = code_q;
        wdata_d[`SRF_TRL_ACK_LO +: 4] = rx_ack_seen;
      end
      default: state_d = srf_pkg::SRF_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= srf_pkg::SRF_IDLE;
      remain_q <= '0;
      busy_b_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= `SRF_WORD_ZERO;
      code_q <= 4'h0;
    end else begin
      state_q <= state_d;
      remain_q <= remain_d;
      busy_b_q <= busy_b_d;
      wr_q <= wr_d;
      wdata_q <= wdata_d;
      code_q <= code_d;
    end
  end

  assign general_receive_fifo_wr = wr_q;
  assign general_receive_fifo_data = wdata_q;

  // ==========================================
  // Phy configuration path
  assign cfg_if.wr_valid = async_transmit_fifo_wr;
  assign cfg_if.wr_addr = async_transmit_fifo_addr;
  assign cfg_if.wr_data = async_transmit_fifo_data;
  srf_phycfg u_phycfg (
    .clk(clk),
    .reset_n(reset_n),
    .cfg(cfg_if.rewriter)
  );
  assign phy_tx_valid = cfg_if.out_valid;
  assign phy_tx_data = cfg_if.out_data;
  assign phy_tx_is_cfg = cfg_if.out_is_cfg;
endmodule : srf_rx_format

//--- tb/srf_rx_monitor.sv
// Port assertions for the receive formatter.
// Assumes one clock domain; bound to srf_rx_format.
`timescale 1ns/1ps
module srf_rx_monitor (
  // Receive side
  input wire logic clk,
  input wire logic reset_n,
  input wire logic snoop_enable,
  input wire logic rx_start,
  input wire srf_pkg::srf_kind_t rx_kind,
  input wire logic [31:0] rx_header,
  input wire logic rx_end,
  input wire logic rx_truncated,
  input wire logic [1:0] rx_speed,
  input wire logic [3:0] rx_ack_seen,
  input wire logic cycle_end,
  input wire logic general_receive_fifo_wr,
  input wire logic [31:0] general_receive_fifo_data,
  // Phy side
  input wire logic async_transmit_fifo_wr,
  input wire logic [7:0] async_transmit_fifo_addr,
  input wire logic [31:0] async_transmit_fifo_data,
  input wire logic phy_tx_valid,
  input wire logic [31:0] phy_tx_data,
  input wire logic phy_tx_is_cfg
);
  // ==========
  // Idle tracking
  logic busy_q;
  logic tail_q;
  wire rdy = ~busy_q & ~tail_q;
  wire iso = rx_start & rdy & ~cycle_end & ~snoop_enable & (rx_kind == srf_pkg::SRF_KIND_ISO);
  wire snp = rx_end & snoop_enable;
  wire cfg = async_transmit_fifo_wr & (async_transmit_fifo_addr == 8'h80);
  wire wr = general_receive_fifo_wr;
  wire [31:0] d = general_receive_fifo_data;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      tail_q <= 1'b0;
    end else begin
      busy_q <= (busy_q | rx_start) & ~rx_end;
      tail_q <= rx_end;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_iso_tag: assert property (iso |=> wr && d[15:14] == 2'h0)
    else $error("iso tag");
  a_iso_tcode: assert property (iso |=> wr && d[7:4] == 4'hA)
    else $error("iso tcode");
  a_iso_keep: assert property (iso |=> (d & 32'hFFFF3F0F) == ($past(rx_header) & 32'hFFFF3F0F))
    else $error("iso fields");
  a_cycle_mark: assert property (cycle_end & rdy & ~rx_start & ~snoop_enable |=> wr && d == 32'h1)
    else $error("cycle mark");
  a_snoop_take: assert property (rx_start & rdy & ~cycle_end & snoop_enable |=> wr && d == $past(rx_header))
    else $error("snoop header");
  a_snoop_done: assert property (snp & ~rx_truncated |=> ##1 wr && d[3:0] == 4'h1)
    else $error("snoop status");
  a_snoop_ack: assert property (snp |=> ##1 d[7:4] == $past(rx_ack_seen) && d[17:16] == $past(rx_speed))
    else $error("snoop ack");
  a_cfg_edit: assert property (cfg && async_transmit_fifo_data[15:0] == 16'h00E0 |=> phy_tx_is_cfg
    && phy_tx_valid && (phy_tx_data ^ $past(async_transmit_fifo_data)) == 32'hE0)
    else $error("config rewrite");
endmodule : srf_rx_monitor

bind srf_rx_format srf_rx_monitor u_mon (.*);

//--- tb/srf_phy_model.sv
// Front-end model playing packets into the formatter.
// Assumes the bench calls pkt and mark; drives 1 ns after the edge.
`timescale 1ns/1ps
module srf_phy_model (
  // Clock
  input wire logic clk,
  // Packet stream
  output logic rx_start,
  output srf_pkg::srf_kind_t rx_kind,
  output logic [31:0] rx_header,
  output logic rx_addr_match,
  output logic rx_valid,
  output logic [31:0] rx_data,
  output logic rx_end,
  output logic rx_truncated,
  output logic rx_crc_ok,
  output logic rx_data_ok,
  output logic [1:0] rx_speed,
  output logic [3:0] rx_ack_seen,
  output logic cycle_end
);
  // ==========
  // Player; address never matches, stale lines show inverted data
  initial begin
    {rx_start, rx_addr_match, rx_valid, rx_end, rx_truncated, rx_crc_ok, rx_data_ok, cycle_end} = '0;
    {rx_header, rx_data, rx_speed, rx_ack_seen} = '0;
    rx_kind = srf_pkg::SRF_KIND_ISO;
  end
  task automatic pkt(input srf_pkg::srf_kind_t k, input logic [31:0] h, input int n, input logic [31:0] b,
    input logic [2:0] st, input logic [5:0] sa);
    @(posedge clk) #1;
    rx_start = 1'b1;
    rx_kind = k;
    rx_header = h;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) #1;
      rx_start = 1'b0;
      rx_header = ~h;
      rx_valid = 1'b1;
      rx_data = b + i;
      rx_end = (i == n - 1);
      {rx_truncated, rx_crc_ok, rx_data_ok} = st;
    end
    @(posedge clk) #1;
    {rx_valid, rx_end} = 2'h0;
    rx_data = ~rx_data;
    {rx_speed, rx_ack_seen} = sa;
    @(posedge clk) #1;
    {rx_speed, rx_ack_seen} = ~sa;
  endtask : pkt
  task automatic mark();
    @(posedge clk) #1;
    cycle_end = 1'b1;
    @(posedge clk) #1;
    cycle_end = 1'b0;
  endtask : mark
endmodule : srf_phy_model

//--- tb/srf_rx_format_bench.sv
// Self-checking bench for the receive formatter.
// Assumes srf_phy_model on the front end and the bound monitor.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t got %h exp %h", $time, a, e); end end
module srf_rx_format_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic snoop_enable = 1'b0;
  logic receive_selfid_enable = 1'b0;
  logic async_transmit_fifo_wr = 1'b0;
  logic [7:0] async_transmit_fifo_addr = 8'h00;
  logic [31:0] async_transmit_fifo_data = 32'h0;
  logic rx_start, rx_addr_match, rx_valid, rx_end, rx_truncated, rx_crc_ok, rx_data_ok, cycle_end;
  srf_pkg::srf_kind_t rx_kind;
  logic [31:0] rx_header, rx_data, general_receive_fifo_data, phy_tx_data;
  logic [1:0] rx_speed;
  logic [3:0] rx_ack_seen;
  logic general_receive_fifo_wr, phy_tx_valid, phy_tx_is_cfg;
  logic [31:0] got[$];
  int checked = 0;
  int failures = 0;
  int cyc = 0;
  srf_phy_model u_phy (.*);
  srf_rx_format u_dut (.*);
  // ==========
  // Clock, timeout, FIFO collector
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      print_verdict();
    end
  end
  always @(negedge clk) if (general_receive_fifo_wr === 1'b1) got.push_back(general_receive_fifo_data);
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic pop(output logic [31:0] v);
    repeat (4) if (got.size() == 0) @(negedge clk) #1;
    v = 32'hX;
    if (got.size() != 0) v = got.pop_front();
  endtask : pop
  task automatic take(input logic [31:0] e);
    logic [31:0] v;
    pop(v);
    `CHK(v, e)
  endtask : take
  task automatic done();
    repeat (3) @(posedge clk);
    #1;
    `CHK(got.size(), 0)
  endtask : done
  task automatic t_iso();
    for (int m = 0; m < 3; m++) begin
      u_phy.pkt(srf_pkg::SRF_KIND_ISO, 32'h0005_EA35, 3, 32'hA1B2C3D4, {1'b0, m != 1, m != 2}, {m[1:0], 4'h2});
      take(32'h0005_2AA5);
      take(32'hA1B2C3D4);
      take(32'hA100_0000);
      take({14'h0, m[1:0], 8'h0, 4'h2, m == 0 ? 4'h1 : (m == 1 ? 4'hE : 4'hD)});
      done();
    end
  endtask : t_iso
  task automatic t_snoop();
    logic [31:0] t[2];
    snoop_enable = 1'b1;
    u_phy.pkt(srf_pkg::SRF_KIND_ASYNC, 32'h1234_5678, 2, 32'h0, 3'h3, 6'h1B);
    take(32'h1234_5678);
    take(32'h0);
    take(32'h1);
    take({14'h0, 2'h1, 8'h0, 4'hB, 4'h1});
    for (int i = 0; i < 2; i++) begin
      u_phy.pkt(srf_pkg::SRF_KIND_ISO, 32'h0, 1, 32'h5, 3'h7, 6'h2C);
      take(32'h0);
      take(32'h5);
      pop(t[i]);
    end
    `CHK(t[0][3:0] ^ t[1][3:0], 4'h3)
    `CHK({t[0][3:2], t[0][1] ^ t[0][0]}, 3'h3)
    done();
    snoop_enable = 1'b0;
  endtask : t_snoop
  task automatic t_sid();
    u_phy.pkt(srf_pkg::SRF_KIND_SELFID, 32'h8, 1, 32'h9, 3'h3, 6'h0);
    done();
    receive_selfid_enable = 1'b1;
    for (int i = 0; i < 2; i++) begin
      u_phy.pkt(srf_pkg::SRF_KIND_SELFID, 32'h8, 1, 32'h9, {1'b0, i == 0, 1'b1}, 6'h0);
      take(32'h8);
      take(32'h9);
      take({31'h0, i == 0});
    end
    u_phy.mark();
    take(32'h1);
    done();
  endtask : t_sid
  task automatic t_cfg();
    async_transmit_fifo_wr = 1'b1;
    async_transmit_fifo_addr = 8'h80;
    async_transmit_fifo_data = 32'h3F4C_00E0;
    @(posedge clk) #1;
    async_transmit_fifo_addr = 8'h8C;
    async_transmit_fifo_data = 32'hC0B3_FFFF;
    `CHK({phy_tx_valid, phy_tx_is_cfg, phy_tx_data}, {2'h3, 32'h3F4C_0000})
    @(posedge clk) #1;
    async_transmit_fifo_wr = 1'b0;
    `CHK({phy_tx_valid, phy_tx_is_cfg, phy_tx_data}, {2'h2, 32'hC0B3_FFFF})
    @(posedge clk) #1;
    `CHK(phy_tx_valid, 1'b0)
  endtask : t_cfg
  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_iso();
    t_snoop();
    t_sid();
    t_cfg();
    print_verdict();
  end
endmodule : srf_rx_format_bench
